// file: design/dds_cal_seq.sv
// DAC calibration sequencer stepping on the calibration clock enable
// assumes startReq is a one-cycle pulse
module dds_cal_seq
   import dds_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic nRstSync,
   input wire logic ce,
   input wire logic startReq,
   input wire logic calClkEn,
   output logic busy,
   output logic done
);
   dds_cal_state_t state;
   logic [7:0] count;
   always_ff @(posedge mclk or negedge nRstSync)
   begin
      if (!nRstSync)
      begin
         state <= CAL_IDLE;
         count <= 8'h00;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (ce)
      begin
         done <= 1'b0;
         case (state)
            CAL_IDLE:
               if (startReq)
               begin
                  state <= CAL_WAIT; // R18
                  busy <= 1'b1;
               end
            CAL_WAIT:
               if (calClkEn)
               begin
                  state <= CAL_RUN;
                  count <= 8'h00;
               end
            CAL_RUN:
               if (calClkEn) // R6
               begin
                  if (count == CAL_RUN_CYCLES - 8'h01)
                  begin
                     state <= CAL_IDLE;
                     busy <= 1'b0;
                     done <= 1'b1;
                  end
                  else
                     count <= count + 8'h01;
               end
            default:
               state <= CAL_IDLE;
         endcase
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nRstSync);
   a_cal_clk_hold: assert property // R6
      (ce && state == CAL_RUN && !calClkEn |=> $stable(count))
      else $error("calibration advanced with its clock stopped");
   a_cal_start: assert property // R18
      (ce && state == CAL_IDLE && startReq |=> busy)
      else $error("start request did not begin a calibration");
   c_cal_done: cover property (done);
endmodule : dds_cal_seq

// file: design/dds_cfg_pkg.sv
// package of constants for the synthesizer configuration register slice
// assumes a single 40 MHz clock and a word-wide programming port
// Notes on behaviour
// (R1) lock detection runs only while lock-detect enable bit 2 is set
// (R2) lock after phase error stays in window 128/256/512/1024 ref cycles
// (R3) lock state readable at bit 24 of status address 0x00
// (R4) bit 6 clear: automatic pump current; set: manual code bits [5:3]
// (R5) converter bit 26 low enables sync output, high disables it
// (R6) calibration clock runs only with bits 25 and 26 both low
// (R7) writing 1 to converter bit 24 starts a DAC calibration
// (R8) host calibrates the DAC after power-up and clock changes
// (R9) host writes only default values into converter bits [23:0]
// (R10) ramp registers 0x04..0x08 act only while 0x01 bit 19 set
// (R11) lower limit at 0x04, upper limit at 0x05 bound the sweep
// (R12) 0x06 is the step added on each rising step
// (R13) 0x07 is the step subtracted on each falling step
// (R14) 0x08 upper half sets interval between falling steps
// (R15) 0x08 lower half sets interval between rising steps
// (R16) host starts VCO calibration whenever it enables the PLL
// (R17) lock held low while disabled; window count restarts on exit
// (R18) calibration runs once per rising edge of the enable bit
package dds_cfg_pkg;
   // -------------------------------------------------------------
   // register addresses
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_RAMP_MODE = 8'h01;
   localparam logic [7:0] ADDR_PLL_CTRL = 8'h02;
   localparam logic [7:0] ADDR_CONV_CTRL = 8'h03;
   localparam logic [7:0] ADDR_RAMP_LOWER = 8'h04;
   localparam logic [7:0] ADDR_RAMP_UPPER = 8'h05;
   localparam logic [7:0] ADDR_RAMP_RISE = 8'h06;
   localparam logic [7:0] ADDR_RAMP_FALL = 8'h07;
   localparam logic [7:0] ADDR_RAMP_RATE = 8'h08;
   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int STAT_LOCK_BIT = 24;
   localparam int RAMP_EN_BIT = 19;
   localparam int CP_MANUAL_BIT = 6;
   localparam int CP_CODE_LSB = 3;
   localparam int LOCK_EN_BIT = 2;
   localparam int LOCK_WIN_LSB = 0;
   localparam int AUX_PD_BIT = 26;
   localparam int CALCLK_PD_BIT = 25;
   localparam int CAL_EN_BIT = 24;
   localparam int FALL_RATE_LSB = 16;
   localparam int RISE_RATE_LSB = 0;
   // -------------------------------------------------------------
   // reset values and timing counts
   // -------------------------------------------------------------
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [10:0] LOCK_WIN_BASE = 11'h080;
   localparam logic [7:0] CAL_RUN_CYCLES = 8'h40;
   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_WAIT = 3'b010,
      CAL_RUN = 3'b100
   } dds_cal_state_t;
endpackage : dds_cfg_pkg

// file: design/dds_lock_detect.sv
// reference-cycle lock-window counter
// assumes refTick is one pulse per reference cycle, synchronous to mclk
module dds_lock_detect
   import dds_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic nRstSync,
   input wire logic ce,
   input wire logic detectEnable,
   input wire logic [1:0] windowCode,
   input wire logic refTick,
   input wire logic phaseInWindow,
   output logic locked
);
   logic [10:0] count;
   logic [10:0] target;
   assign target = LOCK_WIN_BASE << windowCode; // R2
   always_ff @(posedge mclk or negedge nRstSync)
   begin
      if (!nRstSync)
      begin
         count <= 11'h000;
         locked <= 1'b0;
      end
      else if (ce)
      begin
         if (!detectEnable)
         begin
            count <= 11'h000; // R1 R17
            locked <= 1'b0; // R17
         end
         else if (refTick && !phaseInWindow)
         begin
            count <= 11'h000; // R17
            locked <= 1'b0;
         end
         else if (refTick)
         begin
            if (count < target)
               count <= count + 11'h001;
            if (count >= target - 11'h001)
               locked <= 1'b1; // R2
         end
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nRstSync);
   a_lock_off_dis: assert property (ce && !detectEnable |=> !locked) // R1
      else $error("lock stayed set while detection disabled");
   a_lock_exit_win: assert property // R17
      (ce && refTick && !phaseInWindow |=> !locked && count == 11'h000)
      else $error("lock or count kept after leaving window");
   a_lock_rise_cnt: assert property // R2
      ($rose(locked) |-> $past(count) >= $past(target) - 11'h001)
      else $error("lock set before window count reached");
endmodule : dds_lock_detect

// file: design/dds_pll_dac_ramp_cfg.sv
// top of the configuration slice: programming port, registers, outputs
// assumes port strobes are synchronous to mclk, one request per cycle
module dds_pll_dac_ramp_cfg
   import dds_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic refTick,
   input wire logic phaseInWindow,
   output logic [31:0] regRdData,
   output logic regRdValid,
   output logic pllLocked,
   output logic cpManual,
   output logic [2:0] cpCode,
   output logic syncOutOn,
   output logic dacCalClkOn,
   output logic dacCalActive,
   output logic rampEnable,
   output logic [31:0] rampLower,
   output logic [31:0] rampUpper,
   output logic [31:0] rampRiseStep,
   output logic [31:0] rampFallStep,
   output logic [15:0] rampFallInterval,
   output logic [15:0] rampRiseInterval
);
   // -------------------------------------------------------------
   // reset release
   // -------------------------------------------------------------
   logic rstMeta;
   logic nRstSync;
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         rstMeta <= 1'b0;
         nRstSync <= 1'b0;
      end
      else
      begin
         rstMeta <= 1'b1;
         nRstSync <= rstMeta;
      end
   end

   // -------------------------------------------------------------
   // register storage
   // -------------------------------------------------------------
   logic [31:0] rampModeConfig;
   logic [31:0] pllLockCtrl;
   logic [31:0] convCtrl;
   logic [31:0] lowerLimit;
   logic [31:0] upperLimit;
   logic [31:0] riseStep;
   logic [31:0] fallStep;
   logic [31:0] slopeRates;
   logic calDone;
   logic calBusy;
   logic calStart;
   logic calClkEn;
   logic lockedRaw;
   logic wrConv;

   assign wrConv = regWrite && regAddr == ADDR_CONV_CTRL;
   // start only on a 0 to 1 change of the stored enable bit
   assign calStart = wrConv && regWrData[CAL_EN_BIT]
      && !convCtrl[CAL_EN_BIT]; // R7 R18
   assign calClkEn = !convCtrl[CALCLK_PD_BIT]
      && !convCtrl[AUX_PD_BIT]; // R6

   always_ff @(posedge mclk or negedge nRstSync)
   begin
      if (!nRstSync)
         rampModeConfig <= RESET_WORD;
      else if (ce && regWrite && regAddr == ADDR_RAMP_MODE)
         rampModeConfig <= regWrData;
   end

   always_ff @(posedge mclk or negedge nRstSync)
   begin
      if (!nRstSync)
         pllLockCtrl <= RESET_WORD;
      else if (ce && regWrite && regAddr == ADDR_PLL_CTRL)
         pllLockCtrl <= regWrData;
   end

   // converter control: the enable bit clears itself when calibration
   // ends, but a write landing in that cycle wins
   always_ff @(posedge mclk or negedge nRstSync)
   begin
      if (!nRstSync)
         convCtrl <= RESET_WORD;
      else if (ce)
      begin
         if (wrConv)
            convCtrl <= regWrData; // R9
         else if (calDone)
            convCtrl[CAL_EN_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nRstSync)
   begin
      if (!nRstSync)
      begin
         lowerLimit <= RESET_WORD;
         upperLimit <= RESET_WORD;
      end
      else if (ce && regWrite)
      begin
         if (regAddr == ADDR_RAMP_LOWER)
            lowerLimit <= regWrData; // R11
         if (regAddr == ADDR_RAMP_UPPER)
            upperLimit <= regWrData; // R11
      end
   end

   always_ff @(posedge mclk or negedge nRstSync)
   begin
      if (!nRstSync)
      begin
         riseStep <= RESET_WORD;
         fallStep <= RESET_WORD;
         slopeRates <= RESET_WORD;
      end
      else if (ce && regWrite)
      begin
         if (regAddr == ADDR_RAMP_RISE)
            riseStep <= regWrData; // R12
         if (regAddr == ADDR_RAMP_FALL)
            fallStep <= regWrData; // R13
         if (regAddr == ADDR_RAMP_RATE)
            slopeRates <= regWrData; // R14 R15
      end
   end

   // -------------------------------------------------------------
   // lock detection and calibration
   // -------------------------------------------------------------
   dds_lock_detect uLock (
      .mclk(mclk),
      .nRstSync(nRstSync),
      .ce(ce),
      .detectEnable(pllLockCtrl[LOCK_EN_BIT]),
      .windowCode(pllLockCtrl[LOCK_WIN_LSB +: 2]),
      .refTick(refTick),
      .phaseInWindow(phaseInWindow),
      .locked(lockedRaw)
   );

   dds_cal_seq uCal (
      .mclk(mclk),
      .nRstSync(nRstSync),
      .ce(ce),
      .startReq(calStart),
      .calClkEn(calClkEn),
      .busy(calBusy),
      .done(calDone)
   );

   // -------------------------------------------------------------
   // read port
   // -------------------------------------------------------------
   logic [31:0] next_rdData;
   always_comb
   begin
      next_rdData = 32'h0000_0000;
      case (regAddr)
         ADDR_STATUS:
            next_rdData[STAT_LOCK_BIT] = lockedRaw; // R3
         ADDR_RAMP_MODE:
            next_rdData = rampModeConfig;
         ADDR_PLL_CTRL:
            next_rdData = pllLockCtrl;
         ADDR_CONV_CTRL:
            next_rdData = convCtrl;
         ADDR_RAMP_LOWER:
            next_rdData = lowerLimit;
         ADDR_RAMP_UPPER:
            next_rdData = upperLimit;
         ADDR_RAMP_RISE:
            next_rdData = riseStep;
         ADDR_RAMP_FALL:
            next_rdData = fallStep;
         ADDR_RAMP_RATE:
            next_rdData = slopeRates;
         default:
            next_rdData = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or negedge nRstSync)
   begin
      if (!nRstSync)
      begin
         regRdData <= 32'h0000_0000;
         regRdValid <= 1'b0;
      end
      else if (ce)
      begin
         regRdValid <= regRead;
         if (regRead)
            regRdData <= next_rdData;
      end
   end

   // -------------------------------------------------------------
   // pll and converter outputs
   // -------------------------------------------------------------
   always_ff @(posedge mclk or negedge nRstSync)
   begin
      if (!nRstSync)
      begin
         pllLocked <= 1'b0;
         cpManual <= 1'b0;
         cpCode <= 3'h0;
      end
      else if (ce)
      begin
         pllLocked <= lockedRaw; // R3
         cpManual <= pllLockCtrl[CP_MANUAL_BIT]; // R4
         // code is only meaningful in manual mode; zero otherwise
         cpCode <= pllLockCtrl[CP_MANUAL_BIT]
            ? pllLockCtrl[CP_CODE_LSB +: 3] : 3'h0; // R4
      end
   end

   always_ff @(posedge mclk or negedge nRstSync)
   begin
      if (!nRstSync)
      begin
         syncOutOn <= 1'b0;
         dacCalClkOn <= 1'b0;
         dacCalActive <= 1'b0;
      end
      else if (ce)
      begin
         syncOutOn <= !convCtrl[AUX_PD_BIT]; // R5
         dacCalClkOn <= calClkEn; // R6
         dacCalActive <= calBusy; // R7
      end
   end

   // -------------------------------------------------------------
   // ramp parameter outputs, zero while the ramp is disabled
   // -------------------------------------------------------------
   logic rampOn;
   assign rampOn = rampModeConfig[RAMP_EN_BIT];
   always_ff @(posedge mclk or negedge nRstSync)
   begin
      if (!nRstSync)
      begin
         rampEnable <= 1'b0;
         rampLower <= 32'h0000_0000;
         rampUpper <= 32'h0000_0000;
         rampRiseStep <= 32'h0000_0000;
         rampFallStep <= 32'h0000_0000;
         rampFallInterval <= 16'h0000;
         rampRiseInterval <= 16'h0000;
      end
      else if (ce)
      begin
         rampEnable <= rampOn; // R10
         rampLower <= rampOn ? lowerLimit : 32'h0000_0000; // R10 R11
         rampUpper <= rampOn ? upperLimit : 32'h0000_0000; // R11
         rampRiseStep <= rampOn ? riseStep : 32'h0000_0000; // R12
         rampFallStep <= rampOn ? fallStep : 32'h0000_0000; // R13
         rampFallInterval <= rampOn
            ? slopeRates[FALL_RATE_LSB +: 16] : 16'h0000; // R14
         rampRiseInterval <= rampOn
            ? slopeRates[RISE_RATE_LSB +: 16] : 16'h0000; // R15
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nRstSync);

   // nRstSync in an antecedent skips the release edge, where the
   // output flops still sit in reset
   a_status_lock: assert property // R3
      (ce && regRead && regAddr == ADDR_STATUS
       |=> regRdData[STAT_LOCK_BIT] == $past(lockedRaw))
      else $error("status read does not show lock state");
   a_lock_out: assert property // R3
      (ce |=> pllLocked == $past(lockedRaw))
      else $error("lock output lags internal lock");
   a_cp_manual: assert property // R4
      (ce && pllLockCtrl[CP_MANUAL_BIT]
       |=> cpCode == $past(pllLockCtrl[CP_CODE_LSB +: 3]))
      else $error("manual pump code not passed through");
   a_cp_auto: assert property // R4
      (ce && !pllLockCtrl[CP_MANUAL_BIT] |=> !cpManual && cpCode == 3'h0)
      else $error("pump code shown in automatic mode");
   a_sync_out: assert property // R5
      (ce && nRstSync |=> syncOutOn == !$past(convCtrl[AUX_PD_BIT]))
      else $error("sync output enable wrong");
   a_calclk_gate: assert property // R6
      (ce && convCtrl[CALCLK_PD_BIT] |=> !dacCalClkOn)
      else $error("calibration clock ran while powered down");
   a_calclk_on: assert property // R6
      (ce && nRstSync && calClkEn |=> dacCalClkOn)
      else $error("calibration clock stopped while powered up");
   a_cal_kick: assert property // R7
      (ce && calStart && !calBusy |=> ce [*2] |-> dacCalActive)
      else $error("calibration enable write did not start calibration");
   a_cal_clear: assert property // R18
      (ce && calDone && !wrConv |=> !convCtrl[CAL_EN_BIT])
      else $error("calibration enable kept after calibration end");

   a_ramp_gate: assert property // R10
      (ce && !rampOn |=> !rampEnable && rampRiseStep == 32'h0000_0000
       && rampLower == 32'h0000_0000 && rampFallInterval == 16'h0000)
      else $error("ramp value reached output while ramp disabled");
   a_ramp_rates: assert property // R14 R15
      (ce && rampOn |=> rampFallInterval == $past(slopeRates[31:16])
       && rampRiseInterval == $past(slopeRates[15:0]))
      else $error("slope intervals mismatched");
   a_ramp_steps: assert property // R12 R13
      (ce && rampOn |=> rampRiseStep == $past(riseStep)
       && rampFallStep == $past(fallStep)
       && rampUpper == $past(upperLimit)
       && rampLower == $past(lowerLimit))
      else $error("ramp step or limit mismatched");
   a_lower_write: assert property // R11
      (ce && regWrite && regAddr == ADDR_RAMP_LOWER
       |=> lowerLimit == $past(regWrData))
      else $error("lower limit write did not land");
   a_rd_valid: assert property
      (ce && regRead |=> regRdValid)
      else $error("read strobe gave no valid pulse");

   // -------------------------------------------------------------
   // cover points
   // -------------------------------------------------------------
   c_locked: cover property (pllLocked);
   c_cal_run: cover property (dacCalActive ##[1:100] !dacCalActive);
   c_ramp_on: cover property (rampEnable && rampRiseInterval != 16'h0000);
endmodule : dds_pll_dac_ramp_cfg

// file: test/dds_host_model.sv
// host controller model: programming port requests and reference ticks
// assumes the bench calls its tasks; every request launches on rising mclk
module dds_host_model
   import dds_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic [31:0] regRdData,
   input wire logic regRdValid,
   output logic [7:0] regAddr,
   output logic [31:0] regWrData,
   output logic regWrite,
   output logic regRead,
   output logic refTick,
   output logic phaseInWindow
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      regAddr = 8'h00;
      regWrData = 32'h0000_0000;
      regWrite = 1'b0;
      regRead = 1'b0;
      refTick = 1'b0;
      phaseInWindow = 1'b0;
   end
   // released lines show the inverse of the last value
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask : wr
   task rd(input logic [7:0] a, output logic [31:0] d);
      d = 32'hxxxx_xxxx;
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      regAddr <= ~a;
      for (int n = 0; n < 4; n++)
      begin
         @(posedge mclk);
         if (regRdValid === 1'b1)
         begin
            d = regRdData;
            break;
         end
      end
   endtask : rd
   // converter word with calibration start; low bits kept at default
   task cal(input logic [1:0] pd);
      wr(ADDR_CONV_CTRL, {5'h0, pd, 1'b1, 24'h00_0000});
   endtask : cal
   task ticks(input int n, input logic w);
      repeat (n)
      begin
         @(posedge mclk);
         refTick <= 1'b1;
         phaseInWindow <= w;
         @(posedge mclk);
         refTick <= 1'b0;
         phaseInWindow <= ~w;
      end
   endtask : ticks
endmodule : dds_host_model

// file: test/dds_pll_dac_ramp_config_regs_test.sv
// self-checking bench of the configuration slice
// assumes the host model drives the port; seeded xorshift stimulus
module dds_pll_dac_ramp_config_regs_test
   import dds_cfg_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic nrst;
   logic ce;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData;
   logic regWrite, regRead, refTick, phaseInWindow, regRdValid;
   logic pllLocked, cpManual, syncOutOn, dacCalClkOn, dacCalActive;
   logic rampEnable;
   logic [2:0] cpCode;
   logic [31:0] rampLower, rampUpper, rampRiseStep, rampFallStep;
   logic [15:0] rampFallInterval, rampRiseInterval;
   logic [31:0] seed = 32'h853b_67d5;
   int errors = 0;
   int testsRun = 0;
   int cycles = 0;
   int calCycles = 0;

   always #12.5 mclk = ~mclk;

   dds_pll_dac_ramp_cfg dds_pll_dac_ramp_cfg_i (.mclk(mclk), .nrst(nrst),
      .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .refTick(refTick),
      .phaseInWindow(phaseInWindow), .regRdData(regRdData),
      .regRdValid(regRdValid), .pllLocked(pllLocked), .cpManual(cpManual),
      .cpCode(cpCode), .syncOutOn(syncOutOn), .dacCalClkOn(dacCalClkOn),
      .dacCalActive(dacCalActive), .rampEnable(rampEnable),
      .rampLower(rampLower), .rampUpper(rampUpper),
      .rampRiseStep(rampRiseStep), .rampFallStep(rampFallStep),
      .rampFallInterval(rampFallInterval),
      .rampRiseInterval(rampRiseInterval));
   dds_host_model dds_host_model_i (.mclk(mclk), .regRdData(regRdData),
      .regRdValid(regRdValid), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .refTick(refTick),
      .phaseInWindow(phaseInWindow));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task chk(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task print_verdict();
      $display("comparisons %0d mismatches %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (dacCalActive === 1'b1)
         calCycles <= calCycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         print_verdict();
      end
   end

   initial
   begin
      logic [31:0] d;
      logic [31:0] rv [5];
      int w;
      int c0;
      nrst = 1'b0;
      ce = 1'b1;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      // -------------------------------------------------------------
      // reset values, unmapped read
      // -------------------------------------------------------------
      for (int n = 0; n < 10; n++)
      begin
         dds_host_model_i.rd((n == 9) ? 8'h3f : 8'(n), d);
         chk("resetWord", d, 32'h0000_0000);
      end
      $display("done: reset values");
      // -------------------------------------------------------------
      // ramp parameter registers
      // -------------------------------------------------------------
      dds_host_model_i.wr(ADDR_RAMP_MODE, 32'h0008_0000);
      for (int n = 0; n < 5; n++)
      begin
         rv[n] = rnd();
         dds_host_model_i.wr(8'(ADDR_RAMP_LOWER + n), rv[n]);
      end
      repeat (2) @(posedge mclk);
      chk("rampEnable", {31'h0, rampEnable}, 32'h0000_0001);
      chk("rampLower", rampLower, rv[0]);
      chk("rampUpper", rampUpper, rv[1]);
      chk("rampRiseStep", rampRiseStep, rv[2]);
      chk("rampFallStep", rampFallStep, rv[3]);
      chk("fallIntv", {16'h0, rampFallInterval}, {16'h0, rv[4][31:16]});
      chk("riseIntv", {16'h0, rampRiseInterval}, {16'h0, rv[4][15:0]});
      for (int n = 0; n < 5; n++)
      begin
         dds_host_model_i.rd(8'(ADDR_RAMP_LOWER + n), d);
         chk("rampRead", d, rv[n]);
      end
      // clock enable low must freeze the registers
      ce <= 1'b0;
      dds_host_model_i.wr(ADDR_RAMP_LOWER, ~rv[0]);
      ce <= 1'b1;
      dds_host_model_i.wr(ADDR_RAMP_MODE, 32'h0000_0000);
      repeat (2) @(posedge mclk);
      chk("rampOff", rampLower, 32'h0000_0000);
      chk("rampOffIntv", {16'h0, rampRiseInterval}, 32'h0000_0000);
      dds_host_model_i.rd(ADDR_RAMP_LOWER, d);
      chk("frozenWrite", d, rv[0]);
      $display("done: ramp registers");
      // -------------------------------------------------------------
      // charge pump selection and power-down bits
      // -------------------------------------------------------------
      for (int n = 0; n < 16; n++)
      begin
         d = {25'h0, n[3], n[2:0], 3'h0};
         dds_host_model_i.wr(ADDR_PLL_CTRL, d);
         repeat (2) @(posedge mclk);
         chk("cpManual", {31'h0, cpManual}, {31'h0, n[3]});
         chk("cpCode", {29'h0, cpCode}, {29'h0, n[3] ? n[2:0] : 3'h0});
      end
      for (int n = 0; n < 4; n++)
      begin
         dds_host_model_i.wr(ADDR_CONV_CTRL, {5'h0, n[1:0], 25'h0});
         repeat (2) @(posedge mclk);
         chk("syncOutOn", {31'h0, syncOutOn}, {31'h0, ~n[1]});
         chk("calClkOn", {31'h0, dacCalClkOn}, {31'h0, n == 0});
      end
      $display("done: pump and power-down");
      // -------------------------------------------------------------
      // calibration: one run per rising edge, stall while clock off
      // -------------------------------------------------------------
      c0 = calCycles;
      dds_host_model_i.cal(2'b00);
      repeat (20) @(posedge mclk);
      dds_host_model_i.cal(2'b00);
      repeat (150) @(posedge mclk);
      c0 = calCycles - c0;
      chk("calLen", {31'h0, c0 inside {[64:66]}}, 32'h0000_0001);
      dds_host_model_i.rd(ADDR_CONV_CTRL, d);
      chk("calSelfClear", d, 32'h0000_0000);
      dds_host_model_i.cal(2'b00);
      repeat (20) @(posedge mclk);
      dds_host_model_i.cal(2'b10);
      repeat (150) @(posedge mclk);
      chk("calStall", {31'h0, dacCalActive}, 32'h0000_0001);
      dds_host_model_i.cal(2'b00);
      repeat (150) @(posedge mclk);
      chk("calResume", {31'h0, dacCalActive}, 32'h0000_0000);
      $display("done: calibration");
      // -------------------------------------------------------------
      // lock detection for every window code
      // -------------------------------------------------------------
      // pll start request goes to the read-only status word: ignored here
      dds_host_model_i.wr(ADDR_STATUS, 32'h0100_0000);
      for (w = 0; w < 4; w++)
      begin
         dds_host_model_i.wr(ADDR_PLL_CTRL, {29'h0, 1'b1, w[1:0]});
         dds_host_model_i.ticks((128 << w) - 1, 1'b1);
         repeat (3) @(posedge mclk);
         chk("earlyLock", {31'h0, pllLocked}, 32'h0000_0000);
         dds_host_model_i.ticks(1, 1'b1);
         repeat (3) @(posedge mclk);
         chk("lock", {31'h0, pllLocked}, 32'h0000_0001);
         dds_host_model_i.rd(ADDR_STATUS, d);
         chk("statusLock", d, 32'h0100_0000);
         dds_host_model_i.ticks(1, 1'b0);
         repeat (3) @(posedge mclk);
         chk("lockLost", {31'h0, pllLocked}, 32'h0000_0000);
      end
      dds_host_model_i.wr(ADDR_PLL_CTRL, 32'h0000_0004);
      dds_host_model_i.ticks(128, 1'b1);
      dds_host_model_i.wr(ADDR_PLL_CTRL, 32'h0000_0000);
      repeat (3) @(posedge mclk);
      chk("lockDisable", {31'h0, pllLocked}, 32'h0000_0000);
      dds_host_model_i.ticks(200, 1'b1);
      chk("lockStaysOff", {31'h0, pllLocked}, 32'h0000_0000);
      $display("done: lock detection");
      print_verdict();
   end
endmodule : dds_pll_dac_ramp_config_regs_test
